// ---- cmi_defs.svh ----
// constants of the correlator multiply and integrate block
// assumes a 200 MHz core clock; included by the core module only
`ifndef CMI_DEFS_SVH
`define CMI_DEFS_SVH

// clock and timing figures in ns
`define CMI_CLK_NS 5
`define CMI_TICK_NS 92800
`define CMI_BLANK_NS 640
`define CMI_SHORT_NS 92160
// cycle counts: event period exact, blanking rounded up
`define CMI_TICK_CYC (`CMI_TICK_NS / `CMI_CLK_NS)
`define CMI_BLANK_CYC ((`CMI_BLANK_NS + `CMI_CLK_NS - 1) / `CMI_CLK_NS)
`define CMI_SHORT_CYC (`CMI_SHORT_NS / `CMI_CLK_NS)

// datapath widths and field positions
`define CMI_CNT_W 14
`define CMI_HOLD_W 12
`define CMI_HOLD_LSB 2
`define CMI_SUM_W 24
`define CMI_SLOT_DW 25
`define CMI_OVF_BIT 24
`define CMI_SLOTS 32
`define CMI_SLOT_AW 5
`define CMI_EVT_W 10
`define CMI_VS_W 32
`define CMI_PH_W 15

// default event count at which the dump task runs
`define CMI_TASK_DUMP 2

// offset product codes
`define CMI_PROD_NEG 2'h0
`define CMI_PROD_ZERO 2'h1
`define CMI_PROD_POS 2'h2

`endif

// ---- cmi_pkg.sv ----
// types shared by the correlator multiply and integrate block
// assumes cmi_defs.svh sits in the include path
`default_nettype none

package cmi_pkg;
    // integrator sequencer, one-bit steps out of idle and within acc and dump, two-bit steps back to idle
    typedef enum logic [2:0] {
        CMI_IDLE = 3'h0,
        CMI_ACC_RD = 3'h1,
        CMI_ACC_WR = 3'h3,
        CMI_DMP_WR = 3'h6,
        CMI_DMP_RD = 3'h2
    } cmi_seq_t;
endpackage

`default_nettype wire

// ---- cmi_slot_ram.sv ----
// small slot memory with one write port and a registered read port
// assumes one clock; read data appear one cycle after rd_en
`default_nettype none

module cmi_slot_ram #(
    parameter int AW = 5,
    parameter int DW = 25
) (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // write and registered read
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

`default_nettype wire

// ---- cmi_core.sv ----
// correlator cell with offset multiply, short integration, serial dump
// and long-term slot integrator with storage section
// assumes sample streams and host strobes on core_clk, gate/waveguide/invalid from pins
`include "cmi_defs.svh"
`default_nettype none

// Function
// RULE1: samples arrive as plus/minus flag codes
// RULE2: product plus one: 2, 1 or 0
// RULE3: 14-bit up counter per 92.16 us period
// RULE4: keep upper 12 bits in holding register
// RULE5: shift holding register out during next period
// RULE6: processor subtracts sample count from results
// RULE7: long integration sums 12-bit results, up to 10 s
// RULE8: 24-bit sum plus overflow flag bit
// RULE9: separate slots for 32 recirculation periods
// RULE10: dump moves sums to storage, bounded time
// RULE11: storage readable while integration continues
// RULE12: divider raises event every 92.8 us
// RULE13: events counted, cleared each waveguide cycle
// RULE14: task runs at its assigned event count
// RULE15: data invalid disables multiplier to integrator path
// RULE16: dump starts at blanking event after host command
// RULE17: count samples contributing to each integration
// RULE18: counters hold during blanking and gated intervals
module cmi_core #(
    parameter int TICK_CYC = `CMI_TICK_CYC,
    parameter int BLANK_CYC = `CMI_BLANK_CYC,
    parameter int TASK_DUMP = `CMI_TASK_DUMP
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic smp_vld,
    input wire logic a_pos,
    input wire logic a_neg,
    input wire logic b_pos,
    input wire logic b_neg,
    input wire logic gate_pin,
    input wire logic wg_pin,
    input wire logic dinv_pin,
    input wire logic [`CMI_SLOT_AW-1:0] rcl_slot,
    input wire logic dump_cmd,
    input wire logic st_rd_en,
    input wire logic [`CMI_SLOT_AW-1:0] st_rd_addr,
    output logic [`CMI_SLOT_DW-1:0] st_rd_data,
    output logic ser_dat,
    output logic ser_vld,
    output logic tick_evt,
    output logic [`CMI_EVT_W-1:0] evt_cnt,
    output logic dump_busy,
    output logic dump_done,
    output logic [`CMI_VS_W-1:0] vs_count
);
    localparam int SW = `CMI_SLOT_DW;
    localparam int AW = `CMI_SLOT_AW;
    // offset product of two three-level codes; both flags set reads as zero
    function automatic logic [1:0] cmi_prod(input logic ap, input logic an, input logic bp, input logic bn);
        logic az;
        logic bz;
        az = (ap == an);
        bz = (bp == bn);
        if (az || bz) begin
            cmi_prod = `CMI_PROD_ZERO; // RULE1
        end else if (ap == bp) begin
            cmi_prod = `CMI_PROD_POS; // RULE2
        end else begin
            cmi_prod = `CMI_PROD_NEG; // RULE2
        end
    endfunction
    // pin synchronisers: gate, waveguide, data invalid
    logic [2:0] pin_in;
    logic [2:0] s1_ff, s2_ff, s3_ff, lvl_ff, wg_prev_ff;
    logic [2:0] nxt_lvl;
    assign pin_in = {dinv_pin, wg_pin, gate_pin};
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff <= 3'h0;
            s2_ff <= 3'h0;
            s3_ff <= 3'h0;
            lvl_ff <= 3'h0;
            wg_prev_ff <= 3'h0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
            wg_prev_ff <= lvl_ff;
        end
    end
    logic gate_ok, wg_rise, dinv;
    assign gate_ok = lvl_ff[0];
    assign wg_rise = lvl_ff[1] & ~wg_prev_ff[1];
    assign dinv = lvl_ff[2];
    // timing: phase divider, event count, multiplier counter, serial out
    logic [`CMI_PH_W-1:0] ph_ff, nxt_ph;
    logic tick_ff, nxt_tick;
    logic [`CMI_EVT_W-1:0] evt_ff, nxt_evt;
    logic [`CMI_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [`CMI_HOLD_W-1:0] hold_ff, nxt_hold;
    logic [3:0] sidx_ff, nxt_sidx;
    logic ser_dat_ff, nxt_ser_dat, ser_vld_ff, nxt_ser_vld;
    logic [`CMI_VS_W-1:0] vs_ff, nxt_vs;
    logic blank, acc_en;
    logic [1:0] prod;
    logic [`CMI_CNT_W:0] cnt_sum;
    assign blank = (ph_ff < `CMI_PH_W'(BLANK_CYC));
    assign acc_en = smp_vld & ~blank & gate_ok & ~dinv; // RULE18
    assign prod = cmi_prod(a_pos, a_neg, b_pos, b_neg);
    assign cnt_sum = {1'b0, cnt_ff} + {{(`CMI_CNT_W-1){1'b0}}, prod};
    always_comb begin
        nxt_tick = (ph_ff == `CMI_PH_W'(TICK_CYC - 1)); // RULE12
        nxt_ph = nxt_tick ? '0 : ph_ff + `CMI_PH_W'(1);
        nxt_evt = evt_ff;
        if (wg_rise) begin
            nxt_evt = '0; // RULE13
        end else if (tick_ff) begin
            nxt_evt = evt_ff + `CMI_EVT_W'(1); // RULE13
        end
        nxt_cnt = cnt_ff;
        nxt_hold = hold_ff;
        nxt_sidx = sidx_ff;
        nxt_ser_vld = 1'b0;
        nxt_ser_dat = 1'b0;
        if (tick_ff) begin
            nxt_hold = cnt_ff[`CMI_CNT_W-1:`CMI_HOLD_LSB]; // RULE4
            nxt_cnt = '0; // RULE3
            nxt_sidx = 4'hC;
        end else if (acc_en) begin
            // saturate rather than wrap on a full-scale period
            nxt_cnt = cnt_sum[`CMI_CNT_W] ? '1 : cnt_sum[`CMI_CNT_W-1:0]; // RULE3
        end
        if (!tick_ff && sidx_ff != 4'h0) begin
            nxt_ser_vld = 1'b1; // RULE5
            nxt_ser_dat = hold_ff[sidx_ff - 4'h1]; // RULE5
            nxt_sidx = sidx_ff - 4'h1;
        end
        nxt_vs = vs_ff + `CMI_VS_W'(acc_en); // RULE17
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ph_ff <= '0;
            tick_ff <= 1'b0;
            evt_ff <= '0;
            cnt_ff <= '0;
            hold_ff <= '0;
            sidx_ff <= 4'h0;
            ser_dat_ff <= 1'b0;
            ser_vld_ff <= 1'b0;
        end else begin
            ph_ff <= nxt_ph;
            tick_ff <= nxt_tick;
            evt_ff <= nxt_evt;
            cnt_ff <= nxt_cnt;
            hold_ff <= nxt_hold;
            sidx_ff <= nxt_sidx;
            ser_dat_ff <= nxt_ser_dat;
            ser_vld_ff <= nxt_ser_vld;
        end
    end

    // integrator sequencer: accumulate one slot per event, dump on command
    cmi_pkg::cmi_seq_t st_ff, nxt_st;
    logic acc_pend_ff, nxt_acc_pend, dmp_pend_ff, nxt_dmp_pend, req_ff, nxt_req;
    logic [AW-1:0] slot_ff, nxt_slot, idx_ff, nxt_idx;
    logic busy_ff, nxt_busy, done_ff, nxt_done;
    logic [`CMI_VS_W-1:0] vs_out_ff, nxt_vs_out;
    logic i_we, i_re, s_we;
    logic [AW-1:0] i_wa, i_ra;
    logic [SW-1:0] i_wd, i_rd;
    logic [`CMI_SUM_W:0] acc_sum;
    assign acc_sum = {1'b0, i_rd[`CMI_SUM_W-1:0]} + (`CMI_SUM_W+1)'(hold_ff); // RULE7
    always_comb begin
        nxt_st = st_ff;
        nxt_acc_pend = acc_pend_ff;
        nxt_dmp_pend = dmp_pend_ff;
        nxt_req = req_ff;
        nxt_slot = slot_ff;
        nxt_idx = idx_ff;
        nxt_done = 1'b0;
        nxt_vs_out = vs_out_ff;
        i_we = 1'b0;
        i_re = 1'b0;
        s_we = 1'b0;
        i_wa = slot_ff;
        i_ra = slot_ff;
        i_wd = '0;
        case (st_ff)
            cmi_pkg::CMI_IDLE: begin
                if (acc_pend_ff) begin
                    nxt_st = cmi_pkg::CMI_ACC_RD;
                    nxt_acc_pend = 1'b0;
                end else if (dmp_pend_ff) begin
                    nxt_st = cmi_pkg::CMI_DMP_RD;
                    nxt_dmp_pend = 1'b0;
                    nxt_idx = '0;
                end
            end
            cmi_pkg::CMI_ACC_RD: begin
                i_re = 1'b1;
                nxt_st = cmi_pkg::CMI_ACC_WR;
            end
            cmi_pkg::CMI_ACC_WR: begin
                i_we = 1'b1;
                // wrap the sum, overflow flag stays set until dumped
                i_wd = {i_rd[`CMI_OVF_BIT] | acc_sum[`CMI_SUM_W], acc_sum[`CMI_SUM_W-1:0]}; // RULE8
                nxt_st = cmi_pkg::CMI_IDLE;
            end
            cmi_pkg::CMI_DMP_RD: begin
                i_re = 1'b1;
                i_ra = idx_ff;
                nxt_st = cmi_pkg::CMI_DMP_WR;
            end
            cmi_pkg::CMI_DMP_WR: begin
                s_we = 1'b1; // RULE10
                i_we = 1'b1;
                i_wa = idx_ff;
                i_wd = '0;
                nxt_idx = idx_ff + AW'(1);
                if (idx_ff == AW'(`CMI_SLOTS - 1)) begin
                    nxt_st = cmi_pkg::CMI_IDLE;
                    nxt_done = 1'b1;
                end else begin
                    nxt_st = cmi_pkg::CMI_DMP_RD;
                end
            end
            default: begin
                nxt_st = cmi_pkg::CMI_IDLE;
            end
        endcase
        nxt_busy = (nxt_st == cmi_pkg::CMI_DMP_RD) || (nxt_st == cmi_pkg::CMI_DMP_WR);
        // events: set wins over the clear above
        if (tick_ff && !dinv) begin
            nxt_acc_pend = 1'b1; // RULE15
            nxt_slot = rcl_slot; // RULE9
        end
        if (tick_ff && req_ff && evt_ff == `CMI_EVT_W'(TASK_DUMP)) begin
            nxt_dmp_pend = 1'b1; // RULE14 RULE16
            nxt_req = 1'b0;
            nxt_vs_out = vs_ff; // RULE17
        end
        if (dump_cmd) begin
            nxt_req = 1'b1; // RULE16
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= cmi_pkg::CMI_IDLE;
            acc_pend_ff <= 1'b0;
            dmp_pend_ff <= 1'b0;
            req_ff <= 1'b0;
            slot_ff <= '0;
            idx_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            vs_ff <= '0;
            vs_out_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            acc_pend_ff <= nxt_acc_pend;
            dmp_pend_ff <= nxt_dmp_pend;
            req_ff <= nxt_req;
            slot_ff <= nxt_slot;
            idx_ff <= nxt_idx;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            // sample count restarts with each long integration
            vs_ff <= (nxt_vs_out != vs_out_ff || (tick_ff && nxt_dmp_pend && !dmp_pend_ff)) ?
                `CMI_VS_W'(acc_en) : nxt_vs;
            vs_out_ff <= nxt_vs_out;
        end
    end

    // integrating section and storage section
    cmi_slot_ram #(.AW(AW), .DW(SW)) u_integ (
        .core_clk(core_clk),
        .wr_en(i_we),
        .wr_addr(i_wa),
        .wr_data(i_wd),
        .rd_en(i_re),
        .rd_addr(i_ra),
        .rd_data(i_rd)
    );
    cmi_slot_ram #(.AW(AW), .DW(SW)) u_store (
        .core_clk(core_clk),
        .wr_en(s_we),
        .wr_addr(idx_ff),
        .wr_data(i_rd),
        .rd_en(st_rd_en), // RULE11
        .rd_addr(st_rd_addr),
        .rd_data(st_rd_data)
    );
    // outputs straight from flip-flops
    assign ser_dat = ser_dat_ff;
    assign ser_vld = ser_vld_ff;
    assign tick_evt = tick_ff;
    assign evt_cnt = evt_ff;
    assign dump_busy = busy_ff;
    assign dump_done = done_ff;
    assign vs_count = vs_out_ff;
    // checks
    tick_gap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick_ff |-> ##1 (!tick_ff)[*8]) else $error("event repeated too soon"); // RULE12
    tick_phase_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick_ff |-> ph_ff == '0) else $error("event off phase zero"); // RULE12
    blank_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ph_ff > 1 && blank) |-> $stable(cnt_ff)) else $error("counter moved in blanking"); // RULE18
    hold_take_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick_ff |=> hold_ff == $past(cnt_ff[`CMI_CNT_W-1:`CMI_HOLD_LSB])) else $error("bad hold"); // RULE4
    cnt_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick_ff |=> cnt_ff == '0) else $error("counter not cleared"); // RULE3
    prod_add_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (acc_en && !tick_ff && !cnt_sum[`CMI_CNT_W]) |=> cnt_ff == $past(cnt_sum[`CMI_CNT_W-1:0]))
        else $error("wrong product sum"); // RULE2
    ser_run_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick_ff |=> ##1 ser_vld_ff[*8] ##1 ser_vld_ff[*4] ##1 !ser_vld_ff) else $error("bad shift out"); // RULE5
    dump_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(busy_ff) |-> $past(dmp_pend_ff)) else $error("dump without command"); // RULE16
    dinv_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tick_ff && dinv && !acc_pend_ff && st_ff == cmi_pkg::CMI_IDLE) |=> !acc_pend_ff)
        else $error("invalid period reached integrator"); // RULE15
    evt_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wg_rise |=> evt_ff == '0) else $error("event count not cleared"); // RULE13
    dump_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(busy_ff) |-> ##[63:66] done_ff) else $error("dump length wrong"); // RULE10
    serial_c: cover property (@(posedge core_clk) disable iff (sys_rst) tick_ff ##1 ser_vld_ff);
    accum_c: cover property (@(posedge core_clk) disable iff (sys_rst) st_ff == cmi_pkg::CMI_ACC_WR);
    dump_c: cover property (@(posedge core_clk) disable iff (sys_rst) done_ff);
endmodule

`default_nettype wire

// ---- cmi_far_end.sv ----
// far-end model: sampler code streams and the array processor readout
// assumes the bench changes levels at the falling edge of core_clk
`default_nettype none

module cmi_far_end (
    input wire logic core_clk,
    input wire logic [1:0] a_sel,
    input wire logic [1:0] b_sel,
    output logic a_pos,
    output logic a_neg,
    output logic b_pos,
    output logic b_neg,
    output logic st_rd_en,
    output logic [4:0] st_rd_addr,
    input wire logic [24:0] st_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // sel bit 0 is the plus flag, bit 1 the minus flag
    assign a_pos = a_sel[0];
    assign a_neg = a_sel[1];
    assign b_pos = b_sel[0];
    assign b_neg = b_sel[1];

    // readout idles with the enable low
    initial begin
        st_rd_en = 1'b0;
        st_rd_addr = 5'h00;
    end

    // one storage read, request held until the word is taken
    task automatic read_slot(input logic [4:0] addr, output logic [24:0] word);
        @(negedge core_clk);
        st_rd_en = 1'b1;
        st_rd_addr = addr;
        repeat (2) @(negedge core_clk);
        word = st_rd_data;
        st_rd_en = 1'b0;
        st_rd_addr = ~addr;
    endtask

    // takes out the plus-one offset of every counted sample
    function automatic logic [31:0] remove_offset(input logic [31:0] raw, input logic [31:0] n);
        return raw - n;
    endfunction
endmodule

`default_nettype wire

// ---- correlator_multiply_integrate_tb.sv ----
// bench for the correlator multiply and integrate block
// assumes cmi_core and cmi_far_end are compiled first; core_clk at 200 MHz
`default_nettype none

module correlator_multiply_integrate_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 400;
    localparam int BLANK = 128;
    localparam int NVAL = TICK - BLANK;
    localparam logic [1:0] TA [7] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h3, 2'h1, 2'h1};
    localparam logic [1:0] TB [7] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h1};
    localparam int TP [7] = '{1, -1, 1, 0, 0, 1, 1};
    localparam logic [6:0] TG = 7'h5F;
    localparam logic [6:0] TD = 7'h40;
    logic core_clk, sys_rst, smp_vld, gate_pin, wg_pin, dinv_pin, dump_cmd, st_rd_en;
    int busy_cycles = 0;
    logic a_pos, a_neg, b_pos, b_neg, ser_dat, ser_vld, tick_evt, dump_busy, dump_done;
    logic [1:0] a_sel, b_sel;
    logic [4:0] rcl_slot, st_rd_addr;
    logic [24:0] st_rd_data, word;
    logic [9:0] evt_cnt;
    logic [31:0] vs_count;
    int fail_count = 0;
    int comparisons = 0;

    // block with a shortened event period
    cmi_core #(.TICK_CYC(TICK), .BLANK_CYC(BLANK), .TASK_DUMP(2)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .smp_vld(smp_vld), .a_pos(a_pos), .a_neg(a_neg),
        .b_pos(b_pos), .b_neg(b_neg), .gate_pin(gate_pin), .wg_pin(wg_pin), .dinv_pin(dinv_pin),
        .rcl_slot(rcl_slot), .dump_cmd(dump_cmd), .st_rd_en(st_rd_en), .st_rd_addr(st_rd_addr),
        .st_rd_data(st_rd_data), .ser_dat(ser_dat), .ser_vld(ser_vld), .tick_evt(tick_evt),
        .evt_cnt(evt_cnt), .dump_busy(dump_busy), .dump_done(dump_done), .vs_count(vs_count));

    // sampler streams and storage reader
    cmi_far_end far_u (
        .core_clk(core_clk), .a_sel(a_sel), .b_sel(b_sel), .a_pos(a_pos), .a_neg(a_neg),
        .b_pos(b_pos), .b_neg(b_neg), .st_rd_en(st_rd_en), .st_rd_addr(st_rd_addr),
        .st_rd_data(st_rd_data));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // counts cycles spent copying into storage; only this process writes it
    always @(posedge core_clk) begin
        if (dump_busy === 1'b1) begin
            busy_cycles <= busy_cycles + 1;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // waits for the next event pulse, bounded
    task automatic wait_tick();
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (tick_evt !== 1'b1 && n < 2 * TICK);
        if (n >= 2 * TICK) check("tick wait", 32'h1, 32'h0);
    endtask

    // collects one 12-bit burst, msb first
    task automatic read_ser(output logic [11:0] v);
        int n;
        n = 0;
        while (ser_vld !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        for (int i = 0; i < 12; i++) begin
            v = {v[10:0], ser_dat};
            @(negedge core_clk);
        end
        check("burst end", 32'h0, 32'(ser_vld));
    endtask

    // host command, then a waveguide edge so the count meets the dump value
    task automatic do_dump();
        int n;
        wait_tick();
        dump_cmd = 1'b1;
        @(negedge core_clk);
        dump_cmd = 1'b0;
        wg_pin = 1'b1;
        repeat (8) @(negedge core_clk);
        wg_pin = 1'b0;
        n = 0;
        while (dump_busy !== 1'b1 && n < 4 * TICK) begin
            @(negedge core_clk);
            n++;
        end
        check("dump at count", 32'h1, 32'(evt_cnt >= 2 && evt_cnt <= 3 && n > TICK));
        n = 0;
        while (dump_done !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check("copy span", 32'h40, 32'(n));
    endtask

    task automatic t_events();
        int n;
        int b0;
        wait_tick();
        b0 = busy_cycles;
        wg_pin = 1'b1;
        repeat (8) @(negedge core_clk);
        wg_pin = 1'b0;
        wait_tick();
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (tick_evt !== 1'b1 && n < 2 * TICK);
        check("tick period", 32'(TICK), 32'(n));
        wait_tick();
        repeat (10) @(negedge core_clk);
        check("event count", 32'h3, 32'(evt_cnt));
        check("unasked dump", 32'h0, 32'(busy_cycles - b0));
        $display("events test done");
    endtask

    // one code pair per period, result read in the following period
    task automatic t_multiply();
        logic [11:0] v;
        logic ok;
        for (int i = 0; i < 7; i++) begin
            wait_tick();
            a_sel = TA[i];
            b_sel = TB[i];
            gate_pin = TG[i];
            dinv_pin = TD[i];
            smp_vld = 1'b1;
            wait_tick();
            read_ser(v);
            ok = TG[i] && !TD[i];
            check("hold", ok ? 32'(((TP[i] + 1) * NVAL) >> 2) : 32'h0, 32'(v));
            if (ok) check("true sum", 32'(TP[i] * NVAL), far_u.remove_offset(32'(v) << 2, NVAL));
        end
        gate_pin = 1'b1;
        dinv_pin = 1'b0;
        $display("multiply test done");
    endtask

    task automatic t_integrate();
        wait_tick();
        smp_vld = 1'b0;
        a_sel = 2'h1;
        b_sel = 2'h1;
        do_dump();
        rcl_slot = 5'h05;
        wait_tick();
        smp_vld = 1'b1;
        repeat (2) wait_tick();
        smp_vld = 1'b0;
        do_dump();
        check("sample count", 32'(2 * NVAL), vs_count);
        far_u.read_slot(5'h05, word);
        check("slot 5", 32'(2 * ((2 * NVAL) >> 2)), 32'(word));
        far_u.read_slot(5'h06, word);
        check("slot 6", 32'h0, 32'(word));
        smp_vld = 1'b1;
        repeat (2) wait_tick();
        smp_vld = 1'b0;
        far_u.read_slot(5'h05, word);
        check("storage kept", 32'(2 * ((2 * NVAL) >> 2)), 32'(word));
        $display("integrate test done");
    endtask

    // watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end

    // reset, then the scenarios in turn
    initial begin
        sys_rst = 1'b1;
        smp_vld = 1'b0;
        gate_pin = 1'b1;
        wg_pin = 1'b0;
        dinv_pin = 1'b0;
        dump_cmd = 1'b0;
        a_sel = 2'h0;
        b_sel = 2'h0;
        rcl_slot = 5'h00;
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        t_events();
        t_multiply();
        t_integrate();
        test_done();
    end
endmodule

`default_nettype wire
